// ===== design/pmon_pkg.sv
// Shared constants and types for the supply supervisor and reset sequencer
package pmon_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int unsigned SYS_CLK_PERIOD_NS = 10;
    // Glitches shorter than this are rejected; rounded up to whole cycles
    localparam int unsigned GLITCH_FILTER_NS = 50;
    localparam int unsigned GLITCH_FILTER_CYC =
        (GLITCH_FILTER_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

    // ****************************************************************
    // Stabilization hold, in periods of the selected oscillator
    // ****************************************************************
    localparam int unsigned HOLD_CRYSTAL_CYC = 1024;
    localparam int unsigned HOLD_RC_CYC = 64;
    localparam int unsigned HOLD_CNT_W = 11;

    // ****************************************************************
    // Oscillator selection from the hardware configuration byte
    // ****************************************************************
    typedef enum logic [1:0] {
        OSC_CRYSTAL = 2'h0,
        OSC_PRECISION_RC = 2'h1,
        OSC_LOW_POWER_RC = 2'h2,
        OSC_UNUSED = 2'h3
    } osc_sel_e;

    // ****************************************************************
    // Sequencer states, one-hot
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_WAIT_SUPPLY = 3'h1,
        ST_STABILIZE = 3'h2,
        ST_RUN = 3'h4
    } seq_state_e;

    // Reset values
    localparam logic RST_INT_RESET = 1'b1;
    localparam logic RST_LOW_VOLTAGE_FLAG = 1'b0;

    // ****************************************************************
    // Comparator results from the analog supply monitor
    // ****************************************************************
    typedef struct packed {
        logic above_release;
        logic below_fail;
    } supply_cmp_s;

endpackage : pmon_pkg

// ===== design/supply_glitch_filter.sv
// Level filter: output follows input only after a stable run of samples
`timescale 1ns/1ps
`default_nettype none

module supply_glitch_filter
#(
    parameter int unsigned FILT_CYC = 5,
    parameter logic RST_LEVEL = 1'b0
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Synchronised level in, filtered level out
    input wire logic level_in,
    output logic level_out
);

    localparam int unsigned CNT_W = $clog2(FILT_CYC + 1);

    logic [CNT_W-1:0] run_cnt_ff;
    logic level_ff;

    // ****************************************************************
    // Stable-run counter
    // ****************************************************************
    // Any sample equal to the current output restarts the run, so a
    // pulse shorter than FILT_CYC cycles never reaches the output
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            run_cnt_ff <= '0;
            level_ff <= RST_LEVEL;
        end
        else if (level_in == level_ff)
        begin
            run_cnt_ff <= '0;
        end
        else if (run_cnt_ff == CNT_W'(FILT_CYC - 1))
        begin
            run_cnt_ff <= '0;
            level_ff <= level_in;
        end
        else
        begin
            run_cnt_ff <= run_cnt_ff + CNT_W'(1);
        end
    end

    assign level_out = level_ff;

endmodule // supply_glitch_filter

`default_nettype wire

// ===== design/power_monitor_reset_sequencer.sv
// Supply supervisor: power-on reset, power-fail reset, low-voltage flag
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1: crystal selected: hold reset 1024 clocks
// R2: RC oscillator selected: hold reset 64 clocks
// R3: leave reset only above release threshold
// R4: below fail threshold asserts internal reset
// R5: filter short supply glitches before acting; the low-voltage flag clear acts on the unfiltered above_release
// R6: supply below release clears low-voltage flag
// R7: supervision active in all operating phases
// R8: crystal is default oscillator after reset
// R9: count after release; fail restarts from zero
module power_monitor_reset_sequencer
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Analog comparator results, asynchronous
    input wire pmon_pkg::supply_cmp_s supply_cmp,
    // Oscillator choice from the configuration byte
    input wire pmon_pkg::osc_sel_e osc_sel,
    // Software sets the low-voltage flag, one-cycle pulse
    input wire logic lvf_set,
    // Reset to CPU and peripherals, active high
    output logic int_rst,
    // Software-readable low-voltage flag
    output logic low_voltage_flag,
    // Sequencer state for observation
    output pmon_pkg::seq_state_e seq_state
);
    import pmon_pkg::*;

    supply_cmp_s cmp_meta_ff;
    supply_cmp_s cmp_sync_ff;
    logic above_filt;
    logic fail_filt;
    seq_state_e state_ff;
    seq_state_e nxt_state;
    logic [HOLD_CNT_W-1:0] hold_cnt_ff;
    logic [HOLD_CNT_W-1:0] hold_last_ff;
    logic int_rst_ff;
    logic lvf_ff;

    // Last count value of the hold for a given oscillator
    function automatic logic [HOLD_CNT_W-1:0] hold_last(input osc_sel_e sel);
        case (sel)
            OSC_PRECISION_RC,
            OSC_LOW_POWER_RC: hold_last = HOLD_CNT_W'(HOLD_RC_CYC - 1); // R2
            default: hold_last = HOLD_CNT_W'(HOLD_CRYSTAL_CYC - 1); // R1 R8
        endcase
    endfunction

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    // Comparators are analog and asynchronous to the selected clock
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            cmp_meta_ff <= '0;
            cmp_sync_ff <= '0;
        end
        else
        begin
            cmp_meta_ff <= supply_cmp;
            cmp_sync_ff <= cmp_meta_ff;
        end
    end

    // ****************************************************************
    // Glitch filters
    // ****************************************************************
    // Both comparator levels filtered, so a dip shorter than the filter
    // neither resets nor drops the release condition
    supply_glitch_filter
    #(
        .FILT_CYC(GLITCH_FILTER_CYC),
        .RST_LEVEL(1'b0)
    )
    u_filt_above
    (
        .sys_clk(sys_clk),
        .srst(srst),
        .level_in(cmp_sync_ff.above_release),
        .level_out(above_filt)
    ); // R5

    supply_glitch_filter
    #(
        .FILT_CYC(GLITCH_FILTER_CYC),
        .RST_LEVEL(1'b0)
    )
    u_filt_fail
    (
        .sys_clk(sys_clk),
        .srst(srst),
        .level_in(cmp_sync_ff.below_fail),
        .level_out(fail_filt)
    ); // R5

    // ****************************************************************
    // Sequencer next state
    // ****************************************************************
    // No stop or idle input gates this logic: supervision never sleeps
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_WAIT_SUPPLY:
            begin
                if (above_filt && !fail_filt)
                begin
                    nxt_state = ST_STABILIZE; // R3 R9
                end
            end
            ST_STABILIZE:
            begin
                if (fail_filt || !above_filt)
                begin
                    nxt_state = ST_WAIT_SUPPLY; // R4 R9
                end
                else if (hold_cnt_ff == hold_last_ff)
                begin
                    nxt_state = ST_RUN; // R1 R2
                end
            end
            ST_RUN:
            begin
                if (fail_filt)
                begin
                    nxt_state = ST_WAIT_SUPPLY; // R4 R7
                end
            end
            default: nxt_state = ST_WAIT_SUPPLY;
        endcase
    end

    // State register
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state_ff <= ST_WAIT_SUPPLY;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************************************
    // Stabilization counter
    // ****************************************************************
    // Oscillator choice latched on entry so a change mid-count is ignored
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            hold_cnt_ff <= '0;
            hold_last_ff <= HOLD_CNT_W'(HOLD_CRYSTAL_CYC - 1); // R8
        end
        else if (state_ff != ST_STABILIZE)
        begin
            hold_cnt_ff <= '0; // R9
            hold_last_ff <= hold_last(osc_sel);
        end
        else
        begin
            hold_cnt_ff <= hold_cnt_ff + HOLD_CNT_W'(1);
        end
    end

    // ****************************************************************
    // Internal reset
    // ****************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            int_rst_ff <= RST_INT_RESET;
        end
        else
        begin
            int_rst_ff <= (nxt_state != ST_RUN); // R3 R4
        end
    end

    // ****************************************************************
    // Low-voltage flag
    // ****************************************************************
    // Hardware clear beats a software set: a low supply must stay visible
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            lvf_ff <= RST_LOW_VOLTAGE_FLAG;
        end
        else if (!cmp_sync_ff.above_release)
        begin
            lvf_ff <= 1'b0; // R6
        end
        else if (lvf_set)
        begin
            lvf_ff <= 1'b1;
        end
    end

    assign int_rst = int_rst_ff;
    assign low_voltage_flag = lvf_ff;
    assign seq_state = state_ff;

endmodule // power_monitor_reset_sequencer

`default_nettype wire

// ===== tb/pmon_properties.sv
// Port assertions for the supply supervisor
`timescale 1ns/1ps
`default_nettype none
module pmon_properties
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Watched ports
    input wire pmon_pkg::supply_cmp_s supply_cmp,
    input wire pmon_pkg::osc_sel_e osc_sel,
    input wire logic lvf_set,
    input wire logic int_rst,
    input wire logic low_voltage_flag,
    input wire pmon_pkg::seq_state_e seq_state
);
    import pmon_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic [10:0] hold_ff;
    osc_sel_e osc_ff;
    // Cycles spent in the count, cleared outside it
    always_ff @(posedge sys_clk)
        hold_ff <= (srst || seq_state != ST_STABILIZE) ? 11'h0 : hold_ff + 11'h1;
    // Oscillator frozen at entry; later changes must not matter
    always_ff @(posedge sys_clk)
        if (seq_state != ST_STABILIZE)
            osc_ff <= osc_sel;
    rst_state_a: assert property (
        int_rst == (seq_state != ST_RUN)) else $error("reset vs state");
    hold_len_a: assert property (
        seq_state == ST_RUN && $past(seq_state) == ST_STABILIZE |->
        hold_ff == ((osc_ff inside {OSC_PRECISION_RC, OSC_LOW_POWER_RC}) ?
        11'h40 : 11'h400)) else $error("hold length");
    entry_up_a: assert property (
        $rose(seq_state == ST_STABILIZE) |->
        $past(supply_cmp.above_release, 6)) else $error("entry no supply");
    fail_rst_a: assert property (
        supply_cmp.below_fail [*8] |-> ##[0:4] int_rst)
        else $error("fail no reset");
    glitch_ign_a: assert property (
        (seq_state == ST_RUN && !supply_cmp.below_fail) ##1
        supply_cmp.below_fail [*3] ##1 !supply_cmp.below_fail [*8] |->
        seq_state == ST_RUN) else $error("glitch reset");
    flag_clr_a: assert property (
        !supply_cmp.above_release [*4] |=> !low_voltage_flag)
        else $error("flag not cleared");
    flag_set_a: assert property (
        supply_cmp.above_release [*4] ##0 lvf_set |=> low_voltage_flag)
        else $error("flag not set");
    stab_back_a: assert property (
        seq_state == ST_STABILIZE ##0 supply_cmp.below_fail [*8] |->
        ##[0:4] seq_state == ST_WAIT_SUPPLY) else $error("count kept");
endmodule // pmon_properties
`default_nettype wire

// ===== tb/cpu_model.sv
// CPU side model: counts cycles run since reset release
`timescale 1ns/1ps
`default_nettype none
module cpu_model
(
    // Clock and reset in
    input wire logic sys_clk,
    input wire logic int_rst,
    // Cycles executed
    output logic [15:0] run_cnt
);
    // Core frozen while reset is held
    always_ff @(posedge sys_clk)
        run_cnt <= int_rst ? 16'h0 : run_cnt + 16'h1;
endmodule // cpu_model
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the supply supervisor
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pmon_pkg::*;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    supply_cmp_s supply_cmp = '0;
    osc_sel_e osc_sel = OSC_CRYSTAL;
    logic lvf_set = 1'b0;
    logic int_rst;
    logic low_voltage_flag;
    seq_state_e seq_state;
    logic [15:0] run_cnt;
    int error_cnt = 0;
    int checks_done = 0;
    always #5 sys_clk = ~sys_clk;
    power_monitor_reset_sequencer dut (.sys_clk(sys_clk), .srst(srst),
        .supply_cmp(supply_cmp), .osc_sel(osc_sel), .lvf_set(lvf_set),
        .int_rst(int_rst), .low_voltage_flag(low_voltage_flag),
        .seq_state(seq_state));
    cpu_model cpu (.sys_clk(sys_clk), .int_rst(int_rst), .run_cnt(run_cnt));
    task automatic end_sim();
        if (error_cnt == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Bounded wait; n gives the cycles spent
    task automatic wait_st(seq_state_e s, output int n);
        n = 0;
        while (seq_state !== s)
        begin
            cyc(1);
            n++;
            if (n > 2000)
            begin
                chk("wait", s, seq_state);
                end_sim();
            end
        end
    endtask
    // Power up, then upset the oscillator choice mid-count
    task automatic t_up(osc_sel_e o, int exp);
        int n;
        osc_sel = o;
        supply_cmp = 2'b10;
        wait_st(ST_STABILIZE, n);
        osc_sel = osc_sel_e'(o ^ 2'h1);
        wait_st(ST_RUN, n);
        chk("hold", exp[15:0], n[15:0]);
        chk("rst run", 16'h0, int_rst);
    endtask
    task automatic t_fail();
        int n;
        supply_cmp = 2'b01;
        wait_st(ST_WAIT_SUPPLY, n);
        chk("rst fail", 16'h1, int_rst);
        chk("flag low", 16'h0, low_voltage_flag);
    endtask
    // Short fail pulse must leave the core running
    task automatic t_glitch();
        logic [15:0] r;
        r = run_cnt;
        supply_cmp.below_fail = 1'b1;
        cyc(3);
        supply_cmp.below_fail = 1'b0;
        cyc(17);
        chk("glitch", r + 16'h14, run_cnt);
    endtask
    task automatic t_flag();
        lvf_set = 1'b1;
        cyc(1);
        lvf_set = 1'b0;
        chk("flag set", 16'h1, low_voltage_flag);
        supply_cmp.above_release = 1'b0;
        cyc(2);
        supply_cmp.above_release = 1'b1;
        cyc(6);
        chk("flag dip", 16'h0, low_voltage_flag);
        chk("dip run", 16'h0, int_rst);
    endtask
    // Fail mid-count must restart the full count; leave RUN first
    task automatic t_restart();
        int n;
        t_fail();
        osc_sel = OSC_CRYSTAL;
        supply_cmp = 2'b10;
        wait_st(ST_STABILIZE, n);
        cyc(30);
        t_fail();
        t_up(OSC_CRYSTAL, 1024);
    endtask
    // Mid-run reset returns every output to its reset value
    task automatic t_reset();
        lvf_set = 1'b1;
        cyc(1);
        lvf_set = 1'b0;
        srst = 1'b1;
        cyc(2);
        srst = 1'b0;
        chk("rst again", 16'h1, int_rst);
        chk("flag again", 16'h0, low_voltage_flag);
        chk("state again", ST_WAIT_SUPPLY, seq_state);
        t_up(OSC_CRYSTAL, 1024);
    endtask
    initial
    begin
        repeat (12) @(posedge sys_clk);
        cyc(1);
        srst = 1'b0;
        chk("rst val", 16'h1, int_rst);
        chk("flag val", 16'h0, low_voltage_flag);
        cyc(40);
        chk("no supply", ST_WAIT_SUPPLY, seq_state);
        t_up(OSC_CRYSTAL, 1024);
        t_glitch();
        t_flag();
        t_fail();
        t_up(OSC_PRECISION_RC, 64);
        t_fail();
        t_up(OSC_LOW_POWER_RC, 64);
        t_fail();
        t_up(OSC_UNUSED, 1024);
        t_restart();
        t_reset();
        end_sim();
    end
endmodule // tb
bind power_monitor_reset_sequencer pmon_properties props (.sys_clk(sys_clk),
    .srst(srst), .supply_cmp(supply_cmp), .osc_sel(osc_sel),
    .lvf_set(lvf_set), .int_rst(int_rst),
    .low_voltage_flag(low_voltage_flag), .seq_state(seq_state));
`default_nettype wire
